// ### bench/rcf_checker.sv
// assertions on the rcf_top ports
// assumes binding into rcf_top, single mclk domain
`timescale 1ns/1ps
module rcf_checker (
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst_b,
    // register port
    input wire logic [11:0] reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    // cause inputs
    input wire logic        brownout_rst_in,
    input wire logic        mem_violation_rst_in,
    input wire logic        watchdog_rst_in,
    input wire logic        master_clear_rst_in,
    input wire logic        reset_instr_in,
    input wire logic        stack_underflow_in,
    input wire logic        stack_overflow_in,
    // outputs
    input wire logic [7:0]  power_control_0,
    input wire logic [7:0]  power_control_1,
    input wire logic        sw_brownout_enable,
    input wire logic        irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // ====
    // cycles since last write or cause activity
    logic [3:0] quiet;
    logic [3:0] next_quiet;
    logic       busy;
    assign busy = reg_wr | brownout_rst_in | mem_violation_rst_in | watchdog_rst_in
                | master_clear_rst_in | reset_instr_in | stack_underflow_in | stack_overflow_in;
    always_comb next_quiet = busy ? 4'h0 : ((quiet == 4'hf) ? quiet : quiet + 4'h1);
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) quiet <= 4'h0;
        else quiet <= next_quiet;
    end
    // ====
    // assertions
    unmapped_zero_a: assert property (reg_rd && (reg_addr < 12'h191 || reg_addr > 12'h195)
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    pc1_bit1_only_a: assert property ((power_control_1 & 8'hfd) == 8'h00)
        else $error("power control 1 spare bit set");
    pc0_spare_a: assert property (!power_control_0[5])
        else $error("power control 0 bit 5 set");
    por_value_a: assert property ($rose(rst_b) |-> power_control_0 == 8'h1d
        && power_control_1 == 8'h02) else $error("power-on values wrong");
    // flag registers 4 edges after the rise is sampled, seen one edge later
    bo_clears_a: assert property ($rose(brownout_rst_in) |-> ##5 power_control_0[1:0] == 2'b00
        && power_control_1[1] && sw_brownout_enable) else $error("brown-out effect wrong");
    bo_keeps_a: assert property ($rose(brownout_rst_in) |-> ##5
        power_control_0[4] == $past(power_control_0[4], 5)) else $error("brown-out hit watchdog flag");
    mem_violation_flag_clears_a: assert property ($rose(mem_violation_rst_in) |-> ##5 !power_control_1[1])
        else $error("violation flag not cleared");
    wdog_clears_a: assert property ($rose(watchdog_rst_in) |-> ##5 !power_control_0[4])
        else $error("watchdog flag not cleared");
    ovf_sets_a: assert property ($rose(stack_overflow_in) |-> ##5 power_control_0[7])
        else $error("overflow flag not set");
    quiet_hold_a: assert property (quiet > 4'h2 |-> $stable(power_control_0)
        && $stable(power_control_1) && $stable(sw_brownout_enable)) else $error("flags moved");
    cover property ($rose(irq));
    cover property ($rose(brownout_rst_in));
    cover property (reg_rd && reg_addr == 12'h196);
endmodule

bind rcf_top rcf_checker rcf_checker_i (.mclk, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_rdata,
    .brownout_rst_in, .mem_violation_rst_in, .watchdog_rst_in, .master_clear_rst_in,
    .reset_instr_in, .stack_underflow_in, .stack_overflow_in, .power_control_0,
    .power_control_1, .sw_brownout_enable, .irq);

// ### bench/tb_rcf_top.sv
// bench for rcf_top against an integer flag model
// assumes 50 MHz mclk and async active-low rst_b
`timescale 1ns/1ps
module tb_rcf_top;
    // ====
    // signals and model state
    logic        mclk, rst_b, reg_wr, reg_rd, bo_rdy, sw, irq, msw;
    logic [11:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, pc0, pc1, m0, m1, mst, mmk;
    logic [6:0]  cause;
    int          errors, tests_run, cyc, i, k;
    rcf_top rcf_top_i (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .brownout_rst_in(cause[0]), .mem_violation_rst_in(cause[1]),
        .watchdog_rst_in(cause[2]), .master_clear_rst_in(cause[3]), .reset_instr_in(cause[4]),
        .stack_underflow_in(cause[5]), .stack_overflow_in(cause[6]), .brownout_ready_in(bo_rdy),
        .power_control_0(pc0), .power_control_1(pc1), .sw_brownout_enable(sw), .irq);
    // ====
    // tasks
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic mreset();
        m0 = 8'h1d;
        m1 = 8'h02;
        msw = 1'b1;
        mst = 8'h00;
        mmk = 8'h00;
    endtask
    function automatic logic [7:0] exp_rd(input logic [11:0] a);
        case (a)
            12'h191: return {msw, 6'h00, bo_rdy};
            12'h192: return m0;
            12'h193: return m1;
            12'h194: return mst;
            12'h195: return mmk;
            default: return 8'h00;
        endcase
    endfunction
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        case (a)
            12'h191: msw = d[7];
            12'h192: m0 = d & 8'hdf;
            12'h193: m1 = d & 8'h02;
            12'h194: mst = mst & ~d;
            12'h195: mmk = d & 8'h7f;
            default: ;
        endcase
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp_rd(a));
    endtask
    task automatic rdall();
        for (int a = 12'h190; a < 12'h197; a++) rd(12'(a));
    endtask
    task automatic ev(input int n);
        @(posedge mclk);
        cause[n] <= 1'b1;
        repeat (5) @(posedge mclk);
        cause[n] <= 1'b0;
        repeat (4) @(posedge mclk);
        case (n)
            0: begin
                m0 = (m0 & 8'h10) | 8'h0c;
                m1 = 8'h02;
                msw = 1'b1;
            end
            1: m1 = 8'h00;
            2: m0 = m0 & 8'hef;
            3: m0 = m0 & 8'hf7;
            4: m0 = m0 & 8'hfb;
            5: m0 = m0 | 8'h40;
            default: m0 = m0 | 8'h80;
        endcase
        mst[n] = 1'b1;
    endtask
    task automatic outs();
        repeat (2) @(posedge mclk);
        #1 chk(pc0, m0);
        chk(pc1, m1);
        chk({6'h00, sw, irq}, {6'h00, msw, |(mst & mmk)});
    endtask
    // ====
    // clock, timeout, main sequence
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            end_of_test();
        end
    end
    initial begin
        {reg_wr, reg_rd, cause, reg_addr, reg_wdata} = '0;
        rst_b = 1'b0;
        errors = 0;
        tests_run = 0;
        cyc = 0;
        void'($urandom(19171));
        bo_rdy = 1'($urandom);
        mreset();
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        outs();
        rdall();
        $display("test reset values done");
        for (i = 0; i < 7; i++) begin
            wr(12'h195, 8'($urandom));
            ev(i);
            outs();
            rdall();
            wr(12'h194, 8'hff);
            outs();
        end
        $display("test cause events done");
        for (i = 0; i < 24; i++) begin
            k = $urandom_range(6, 0);
            if ($urandom_range(2, 0) == 0) ev(k);
            else wr(12'(12'h190 + k), 8'($urandom));
            outs();
            rd(12'(12'h190 + k));
        end
        $display("test random traffic done");
        @(posedge mclk);
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        mreset();
        outs();
        rdall();
        $display("test second reset done");
        end_of_test();
    end
endmodule

// ### src/rcf_pkg.sv
// reset-cause flag block: offsets, bit positions, reset values
// assumes an 8-bit register port with a 12-bit address
package rcf_pkg;

    // =========================================================
    // bus geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 8;

    // =========================================================
    // register offsets
    localparam logic [11:0] OFS_BROWNOUT_CONTROL = 12'h191;
    localparam logic [11:0] OFS_POWER_CONTROL_0  = 12'h192;
    localparam logic [11:0] OFS_POWER_CONTROL_1  = 12'h193;
    localparam logic [11:0] OFS_CAUSE_STATUS     = 12'h194;
    localparam logic [11:0] OFS_CAUSE_MASK       = 12'h195;

    // =========================================================
    // field positions
    localparam int unsigned BIT_STACK_OVF     = 7;
    localparam int unsigned BIT_STACK_UNF     = 6;
    localparam int unsigned BIT_WATCHDOG      = 4;
    localparam int unsigned BIT_MASTER_CLEAR  = 3;
    localparam int unsigned BIT_RESET_INSTR   = 2;
    localparam int unsigned BIT_POWER_ON      = 1;
    localparam int unsigned BIT_BROWNOUT      = 0;
    localparam int unsigned BIT_MEM_VIOLATION = 1;
    localparam int unsigned BIT_SW_BO_ENABLE  = 7;
    localparam int unsigned BIT_BO_READY      = 0;

    // =========================================================
    // implemented-bit masks
    localparam logic [7:0] PC0_IMPL_MASK   = 8'hdf;
    localparam logic [7:0] PC1_IMPL_MASK   = 8'h02;
    localparam logic [7:0] CAUSE_IMPL_MASK = 8'h7f;

    // =========================================================
    // reset values (power-on)
    localparam logic [7:0] PC0_POR_VALUE    = 8'h1d;
    localparam logic [7:0] PC1_POR_VALUE    = 8'h02;
    localparam logic       SW_BO_POR_VALUE  = 1'b1;
    localparam logic [7:0] CAUSE_POR_VALUE  = 8'h00;
    localparam logic [7:0] MASK_POR_VALUE   = 8'h00;

    // =========================================================
    // event and synchroniser indices
    localparam int unsigned EV_BROWNOUT      = 0;
    localparam int unsigned EV_MEM_VIOLATION = 1;
    localparam int unsigned EV_WATCHDOG      = 2;
    localparam int unsigned EV_MASTER_CLEAR  = 3;
    localparam int unsigned EV_RESET_INSTR   = 4;
    localparam int unsigned EV_STACK_UNF     = 5;
    localparam int unsigned EV_STACK_OVF     = 6;
    localparam int unsigned SYNC_BO_READY    = 7;
    localparam int unsigned NUM_SYNC         = 8;

endpackage

// ### src/rcf_sync.sv
// three-stage input synchroniser with agreement filter
// assumes d is asynchronous to mclk
`timescale 1ns/1ps

module rcf_sync (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_b,
    // asynchronous input
    input  wire logic d,
    // filtered level and its rising edge
    output logic      level,
    output logic      rise
);

    logic [2:0] stage;
    logic [2:0] next_stage;
    logic       next_level;
    logic       next_rise;

    // =========================================================
    // next state
    always_comb begin
        next_stage = {stage[1:0], d};
        next_level = level;
        next_rise  = 1'b0;
        // stage[0] feeds only stage[1]
        if (stage[1] == stage[2]) begin
            next_level = stage[2];
            next_rise  = stage[2] & ~level;
        end
    end

    // =========================================================
    // registers
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            stage <= 3'h0;
            level <= 1'b0;
            rise  <= 1'b0;
        end else begin
            stage <= next_stage;
            level <= next_level;
            rise  <= next_rise;
        end
    end

endmodule

// ### src/rcf_top.sv
// reset-cause flags with register port and cause interrupt
// assumes rst_b is the power-on reset; other causes arrive on pins
//
// Local design decision: strobed register access.
`timescale 1ns/1ps

// Contract
// - power-on reset clears power-on flag
// - power-on flag zero on power-on, brown-out
// - brown-out reset clears brown-out flag, also power-on and stack flags
// - firmware writes one; value held until reset
// - memory-violation reset clears violation flag
// - violation flag set on power-on, brown-out
// - power control 1 at 0x193, bit 1
// - firmware may set flags inactive, no side effect
// - each reset changes only matching flags; brown-out also sets master-clear and reset-instruction flags
// - firmware writing active level causes no reset
module rcf_top (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_b,
    // register port
    input  wire logic [11:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // reset-cause inputs and brown-out ready, asynchronous
    input  wire logic        brownout_rst_in,
    input  wire logic        mem_violation_rst_in,
    input  wire logic        watchdog_rst_in,
    input  wire logic        master_clear_rst_in,
    input  wire logic        reset_instr_in,
    input  wire logic        stack_underflow_in,
    input  wire logic        stack_overflow_in,
    input  wire logic        brownout_ready_in,
    // flag and control outputs
    output logic      [7:0]  power_control_0,
    output logic      [7:0]  power_control_1,
    output logic             sw_brownout_enable,
    output logic             irq
);

    // =========================================================
    // input synchronisers
    logic [rcf_pkg::NUM_SYNC-1:0] raw_in;
    logic [rcf_pkg::NUM_SYNC-1:0] sync_level;
    logic [rcf_pkg::NUM_SYNC-1:0] sync_rise;

    always_comb begin
        raw_in                                = '0;
        raw_in[rcf_pkg::EV_BROWNOUT]      = brownout_rst_in;
        raw_in[rcf_pkg::EV_MEM_VIOLATION] = mem_violation_rst_in;
        raw_in[rcf_pkg::EV_WATCHDOG]      = watchdog_rst_in;
        raw_in[rcf_pkg::EV_MASTER_CLEAR]  = master_clear_rst_in;
        raw_in[rcf_pkg::EV_RESET_INSTR]   = reset_instr_in;
        raw_in[rcf_pkg::EV_STACK_UNF]     = stack_underflow_in;
        raw_in[rcf_pkg::EV_STACK_OVF]     = stack_overflow_in;
        raw_in[rcf_pkg::SYNC_BO_READY]    = brownout_ready_in;
    end

    genvar gi;
    generate
        for (gi = 0; gi < rcf_pkg::NUM_SYNC; gi = gi + 1) begin : g_sync
            rcf_sync u_sync (
                .mclk  (mclk),
                .rst_b (rst_b),
                .d     (raw_in[gi]),
                .level (sync_level[gi]),
                .rise  (sync_rise[gi])
            );
        end
    endgenerate

    // events as one-cycle pulses, brown-out ready as a level
    logic ev_brownout;
    logic ev_mem_violation;
    logic ev_watchdog;
    logic ev_master_clear;
    logic ev_reset_instr;
    logic ev_stack_unf;
    logic ev_stack_ovf;
    logic bo_ready;

    always_comb begin
        ev_brownout      = sync_rise[rcf_pkg::EV_BROWNOUT];
        ev_mem_violation = sync_rise[rcf_pkg::EV_MEM_VIOLATION];
        ev_watchdog      = sync_rise[rcf_pkg::EV_WATCHDOG];
        ev_master_clear  = sync_rise[rcf_pkg::EV_MASTER_CLEAR];
        ev_reset_instr   = sync_rise[rcf_pkg::EV_RESET_INSTR];
        ev_stack_unf     = sync_rise[rcf_pkg::EV_STACK_UNF];
        ev_stack_ovf     = sync_rise[rcf_pkg::EV_STACK_OVF];
        bo_ready         = sync_level[rcf_pkg::SYNC_BO_READY];
    end

    // =========================================================
    // address decode
    logic hit_bo_ctl;
    logic hit_pc0;
    logic hit_pc1;
    logic hit_status;
    logic hit_mask;

    always_comb begin
        hit_bo_ctl = (reg_addr == rcf_pkg::OFS_BROWNOUT_CONTROL);
        hit_pc0    = (reg_addr == rcf_pkg::OFS_POWER_CONTROL_0);
        hit_pc1    = (reg_addr == rcf_pkg::OFS_POWER_CONTROL_1);
        hit_status = (reg_addr == rcf_pkg::OFS_CAUSE_STATUS);
        hit_mask   = (reg_addr == rcf_pkg::OFS_CAUSE_MASK);
    end

    // =========================================================
    // flag registers: next values
    logic [7:0] next_pc0;
    logic [7:0] next_pc1;
    logic       next_sw_bo;

    always_comb begin
        next_pc0   = power_control_0;
        next_pc1   = power_control_1;
        next_sw_bo = sw_brownout_enable;

        // firmware stores any value in the implemented bits, no reset is raised
        if (reg_wr && hit_pc0) begin
            next_pc0 = reg_wdata & rcf_pkg::PC0_IMPL_MASK;
        end
        if (reg_wr && hit_pc1) begin
            next_pc1 = reg_wdata & rcf_pkg::PC1_IMPL_MASK;
        end
        if (reg_wr && hit_bo_ctl) begin
            next_sw_bo = reg_wdata[rcf_pkg::BIT_SW_BO_ENABLE];
        end

        // hardware causes win over a firmware write in the same cycle
        if (ev_watchdog) begin
            next_pc0[rcf_pkg::BIT_WATCHDOG] = 1'b0;
        end
        if (ev_master_clear) begin
            next_pc0[rcf_pkg::BIT_MASTER_CLEAR] = 1'b0;
        end
        if (ev_reset_instr) begin
            next_pc0[rcf_pkg::BIT_RESET_INSTR] = 1'b0;
        end
        if (ev_stack_ovf) begin
            next_pc0[rcf_pkg::BIT_STACK_OVF] = 1'b1;
        end
        if (ev_stack_unf) begin
            next_pc0[rcf_pkg::BIT_STACK_UNF] = 1'b1;
        end
        if (ev_mem_violation) begin
            next_pc1[rcf_pkg::BIT_MEM_VIOLATION] = 1'b0;
        end

        // brown-out is the strongest cause and is applied last
        if (ev_brownout) begin
            next_pc0[rcf_pkg::BIT_BROWNOUT]     = 1'b0;
            next_pc0[rcf_pkg::BIT_POWER_ON]     = 1'b0;
            next_pc0[rcf_pkg::BIT_STACK_OVF]    = 1'b0;
            next_pc0[rcf_pkg::BIT_STACK_UNF]    = 1'b0;
            next_pc0[rcf_pkg::BIT_MASTER_CLEAR] = 1'b1;
            next_pc0[rcf_pkg::BIT_RESET_INSTR]  = 1'b1;
            next_pc1[rcf_pkg::BIT_MEM_VIOLATION] = 1'b1;
            next_sw_bo = rcf_pkg::SW_BO_POR_VALUE;
        end
    end

    // flags hold across every reset except power-on and brown-out
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            power_control_0    <= rcf_pkg::PC0_POR_VALUE;
            power_control_1    <= rcf_pkg::PC1_POR_VALUE;
            sw_brownout_enable <= rcf_pkg::SW_BO_POR_VALUE;
        end else begin
            power_control_0    <= next_pc0;
            power_control_1    <= next_pc1;
            sw_brownout_enable <= next_sw_bo;
        end
    end

    // =========================================================
    // cause interrupt: sticky status, mask, level output
    logic [7:0] cause_status;
    logic [7:0] cause_mask;
    logic [7:0] cause_events;
    logic [7:0] next_status;
    logic [7:0] next_mask;
    logic       next_irq;

    always_comb begin
        cause_events = '0;
        cause_events[rcf_pkg::EV_BROWNOUT]      = ev_brownout;
        cause_events[rcf_pkg::EV_MEM_VIOLATION] = ev_mem_violation;
        cause_events[rcf_pkg::EV_WATCHDOG]      = ev_watchdog;
        cause_events[rcf_pkg::EV_MASTER_CLEAR]  = ev_master_clear;
        cause_events[rcf_pkg::EV_RESET_INSTR]   = ev_reset_instr;
        cause_events[rcf_pkg::EV_STACK_UNF]     = ev_stack_unf;
        cause_events[rcf_pkg::EV_STACK_OVF]     = ev_stack_ovf;
    end

    always_comb begin
        next_status = cause_status;
        next_mask   = cause_mask;
        if (reg_wr && hit_status) begin
            next_status = cause_status & ~reg_wdata;
        end
        if (reg_wr && hit_mask) begin
            next_mask = reg_wdata & rcf_pkg::CAUSE_IMPL_MASK;
        end
        // set wins over write-one-to-clear
        next_status = next_status | cause_events;
        next_irq    = |(next_status & next_mask);
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cause_status <= rcf_pkg::CAUSE_POR_VALUE;
            cause_mask   <= rcf_pkg::MASK_POR_VALUE;
            irq          <= 1'b0;
        end else begin
            cause_status <= next_status;
            cause_mask   <= next_mask;
            irq          <= next_irq;
        end
    end

    // =========================================================
    // read port: data valid only in the cycle after the strobe
    logic [7:0] next_rdata;
    logic [7:0] bo_ctl_view;

    always_comb begin
        bo_ctl_view = '0;
        bo_ctl_view[rcf_pkg::BIT_SW_BO_ENABLE] = sw_brownout_enable;
        bo_ctl_view[rcf_pkg::BIT_BO_READY]     = bo_ready;
    end

    always_comb begin
        next_rdata = '0;
        if (reg_rd) begin
            if (hit_bo_ctl) begin
                next_rdata = bo_ctl_view;
            end else if (hit_pc0) begin
                next_rdata = power_control_0 & rcf_pkg::PC0_IMPL_MASK;
            end else if (hit_pc1) begin
                next_rdata = power_control_1 & rcf_pkg::PC1_IMPL_MASK;
            end else if (hit_status) begin
                next_rdata = cause_status;
            end else if (hit_mask) begin
                next_rdata = cause_mask;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

endmodule
